// file: rtl/serial_config_loader.sv
/*
  loading controller end: makes the link clock and collects the bitstream.
  assumes the memory's data wire is resolved by the bench from its enable.
*/
`timescale 1ns/1ps
`include "serial_config_cfg.svh"

module serial_config_loader #(
  parameter int BITS = `SCM_DEPTH_DEFAULT,
  parameter int CW   = (BITS > 1) ? $clog2(BITS + 1) : 1
) (
  // clocking
  input  wire logic          clock,
  input  wire logic          reset,
  // user side
  input  wire logic          start,
  input  wire logic          holdPosition,
  output logic               bitValid,
  output logic               bitData,
  output logic               busy,
  output logic               done,
  // link
  serial_config_if.loader    link
);

  logic [2:0]     dataSync_q;
  logic [3:0]     div_q;
  logic           sclk_q;
  logic           ce_q;
  logic           rst_q;
  logic [CW-1:0]  count_q;
  logic           bitValid_q;
  logic           bitData_q;
  logic           done_q;
  logic           busy_q;
  logic           dataLevel_q;
  serial_config_pkg::load_state_type state_q;

  always_ff @(posedge clock) begin
    dataSync_q <= {dataSync_q[1:0], link.dataOut};
  end

  // the data level counts only once two stages agree
  always_ff @(posedge clock) begin
    if (reset) begin
      dataLevel_q <= `SCM_BIT_ZERO;
    end else if (dataSync_q[2] == dataSync_q[1]) begin
      dataLevel_q <= dataSync_q[2];
    end
  end

  // the link clock is divided down from our own clock and driven out
  always_ff @(posedge clock) begin
    if (reset || state_q != serial_config_pkg::LOAD_RUN) begin
      div_q  <= '0;
      sclk_q <= `SCM_BIT_ZERO;
    end else if (div_q == 4'(`SCM_CLK_DIV_HALF - 1)) begin
      div_q  <= '0;
      sclk_q <= !sclk_q;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  // sample just before the falling edge: a bit needs most of a link period to cross
  // the memory's input synchronisers and then ours
  always_ff @(posedge clock) begin
    if (reset) begin
      state_q    <= serial_config_pkg::LOAD_IDLE;
      ce_q       <= `SCM_BIT_ONE;
      rst_q      <= `SCM_BIT_ZERO;
      count_q    <= '0;
      bitValid_q <= `SCM_BIT_ZERO;
      bitData_q  <= `SCM_BIT_ZERO;
      done_q     <= `SCM_BIT_ZERO;
      busy_q     <= `SCM_BIT_ZERO;
    end else begin
      bitValid_q <= `SCM_BIT_ZERO;
      case (state_q)
        serial_config_pkg::LOAD_IDLE: begin
          // reset/output-enable keeps the level the last load left until the next start
          if (start) begin
            state_q <= serial_config_pkg::LOAD_RUN;
            ce_q    <= `SCM_BIT_ZERO;
            rst_q   <= `SCM_BIT_ONE;
            count_q <= '0;
            done_q  <= `SCM_BIT_ZERO;
            busy_q  <= `SCM_BIT_ONE;
          end
        end
        serial_config_pkg::LOAD_RUN: begin
          if (sclk_q && div_q == 4'(`SCM_CLK_DIV_HALF - 1)) begin
            bitValid_q <= `SCM_BIT_ONE;
            bitData_q  <= dataLevel_q;
            count_q    <= count_q + CW'(1);
            if (count_q == CW'(BITS - 1)) begin
              state_q <= serial_config_pkg::LOAD_FINISH;
            end
          end
        end
        serial_config_pkg::LOAD_FINISH: begin
          ce_q    <= `SCM_BIT_ONE;
          rst_q   <= holdPosition;
          done_q  <= `SCM_BIT_ONE;
          busy_q  <= `SCM_BIT_ZERO;
          state_q <= serial_config_pkg::LOAD_IDLE;
        end
        default: state_q <= serial_config_pkg::LOAD_IDLE;
      endcase
    end
  end

  assign link.configuration_clock_out = sclk_q;
  assign link.chipEnableN             = ce_q;
  assign link.resetOutputEnable       = rst_q;
  assign link.serial_program_enable_n = `SCM_BIT_ONE;
  assign bitValid = bitValid_q;
  assign bitData  = bitData_q;
  assign busy     = busy_q;
  assign done     = done_q;

endmodule

// file: rtl/serial_config_memory.sv
/*
  configuration memory read-out end: shifts stored bits on the link clock.
  assumes the link clock, enables and program-enable arrive unsynchronised.
*/
`timescale 1ns/1ps
`include "serial_config_cfg.svh"

// Notes on behaviour
// - stored bits leave serially on data output
// - controller drives the link clock input
// - chain-enable out feeds next chip-enable in
// - program-enable held high while loading
// - ready pulled low during power-on reset
// - after last bit, chain-enable low, data off
// - chip-enable low enables data output
// - reset level clears every address counter
// - inactive reset level keeps counter position
// - reset polarity is a programmable setting
// - chip-enable high means standby, counter halts
// - standby keeps data output floating
// - reset level clears counter, floats data
// - chip-enable high after reset stays disabled
// - enable active, chip-enable low starts output
// - power-up clears address counter automatically
module serial_config_memory #(
  parameter int DEPTH  = `SCM_DEPTH_DEFAULT,
  parameter int AW     = (DEPTH > 1) ? $clog2(DEPTH) : 1,
  parameter logic [DEPTH-1:0] CONTENT = '0
) (
  // clocking
  input  wire logic    clock,
  input  wire logic    reset,
  // setting
  input  wire logic    resetPolarityHigh,
  // link
  serial_config_if.memory link
);

  logic [2:0]     clkSync_q;
  logic [2:0]     ceSync_q;
  logic [2:0]     rstSync_q;
  logic [2:0]     spSync_q;
  logic           clkLevel_q;
  logic           ceLevel_q;
  logic           rstLevel_q;
  logic           spLevel_q;
  logic [AW-1:0]  addr_q;
  logic [3:0]     por_q;
  logic           polarity_q;
  logic           dataOut_q;
  logic           dataOe_q;
  logic           ceo_q;
  logic           readyOe_q;
  serial_config_pkg::mem_state_type state_q;
  logic           rising;
  logic           inReset;
  logic           active;

  // two stages agreeing filters a pin that is still settling
  function automatic logic stagesAgree(input logic [2:0] sync);
    return sync[2] == sync[1];
  endfunction

  function automatic logic isDone(input serial_config_pkg::mem_state_type st);
    return st == serial_config_pkg::MEM_DONE;
  endfunction

  // three-stage synchronisers; a level counts once stages two and three agree
  always_ff @(posedge clock) begin
    clkSync_q <= {clkSync_q[1:0], link.configuration_clock_out};
  end

  always_ff @(posedge clock) begin
    ceSync_q <= {ceSync_q[1:0], link.chipEnableN};
  end

  always_ff @(posedge clock) begin
    rstSync_q <= {rstSync_q[1:0], link.resetOutputEnable};
  end

  always_ff @(posedge clock) begin
    spSync_q <= {spSync_q[1:0], link.serial_program_enable_n};
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      clkLevel_q <= `SCM_BIT_ZERO;
    end else if (stagesAgree(clkSync_q)) begin
      clkLevel_q <= clkSync_q[2];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ceLevel_q <= `SCM_BIT_ONE;
    end else if (stagesAgree(ceSync_q)) begin
      ceLevel_q <= ceSync_q[2];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rstLevel_q <= `SCM_BIT_ZERO;
    end else if (stagesAgree(rstSync_q)) begin
      rstLevel_q <= rstSync_q[2];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      spLevel_q <= `SCM_BIT_ONE;
    end else if (stagesAgree(spSync_q)) begin
      spLevel_q <= spSync_q[2];
    end
  end

  // polarity is caught at reset release, like a programmed fuse
  always_ff @(posedge clock) begin
    if (reset) begin
      polarity_q <= resetPolarityHigh;
    end
  end

  assign rising  = stagesAgree(clkSync_q) && clkSync_q[2] && !clkLevel_q;
  assign inReset = (rstLevel_q == polarity_q) || (por_q != '0);
  // a low program-enable is programming mode, which this model does not read out
  assign active  = !inReset && !ceLevel_q && spLevel_q;

  // power-on reset counter holds ready low until it runs out
  always_ff @(posedge clock) begin
    if (reset) begin
      por_q <= 4'(`SCM_POR_CYCLES);
    end else if (por_q != '0) begin
      por_q <= por_q - 4'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      readyOe_q <= `SCM_BIT_ONE;
    end else begin
      readyOe_q <= (por_q != '0);
    end
  end

  // address walk; done is sticky until reset level so a chain never rewinds
  always_ff @(posedge clock) begin
    if (reset || inReset) begin
      state_q <= serial_config_pkg::MEM_IDLE;
      addr_q  <= '0;
    end else begin
      case (state_q)
        serial_config_pkg::MEM_IDLE: begin
          if (active) begin
            state_q <= serial_config_pkg::MEM_STREAM;
          end
        end
        serial_config_pkg::MEM_STREAM: begin
          // the address holds on the last bit so its data stays put until the chain moves on
          if (active && rising) begin
            if (addr_q == AW'(DEPTH - 1)) begin
              state_q <= serial_config_pkg::MEM_DONE;
            end else begin
              addr_q <= addr_q + AW'(1);
            end
          end
        end
        serial_config_pkg::MEM_DONE: begin
          state_q <= serial_config_pkg::MEM_DONE;
        end
        default: state_q <= serial_config_pkg::MEM_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      dataOut_q <= `SCM_BIT_ZERO;
    end else begin
      dataOut_q <= CONTENT[addr_q];
    end
  end

  // float on the edge after the last bit so the next chip in the chain can drive
  always_ff @(posedge clock) begin
    if (reset) begin
      dataOe_q <= `SCM_BIT_ZERO;
    end else begin
      dataOe_q <= active && !isDone(state_q);
    end
  end

  // chain enable drops only while finished and out of reset
  always_ff @(posedge clock) begin
    if (reset) begin
      ceo_q <= `SCM_BIT_ONE;
    end else begin
      ceo_q <= !(isDone(state_q) && !inReset);
    end
  end

  assign link.dataOut            = dataOut_q;
  assign link.dataOe             = dataOe_q;
  assign link.chain_enable_out_n = ceo_q;
  assign link.readyOut           = `SCM_BIT_ZERO;
  assign link.readyOe            = readyOe_q;

endmodule

// file: shared/serial_config_cfg.svh
/*
  constants for the serial configuration memory read-out link.
  assumes inclusion by bare name from rtl files; definitions only.
*/
`ifndef SERIAL_CONFIG_CFG_SVH
`define SERIAL_CONFIG_CFG_SVH

`define SCM_DEPTH_DEFAULT      32
`define SCM_POR_CYCLES         8
`define SCM_CLK_DIV_HALF       4
`define SCM_RESET_POL_DEFAULT  1'b0
`define SCM_BIT_ZERO           1'b0
`define SCM_BIT_ONE            1'b1

`endif

// file: shared/serial_config_if.sv
/*
  link between the configuration memory and the loading controller.
  assumes the bench resolves the open-drain ready and the tri-state data wire.
*/
`timescale 1ns/1ps
interface serial_config_if;
  logic configuration_clock_out;
  logic chipEnableN;
  logic resetOutputEnable;
  logic serial_program_enable_n;
  logic dataOut;
  logic dataOe;
  logic chain_enable_out_n;
  logic readyOut;
  logic readyOe;

  modport memory (
    input  configuration_clock_out,
    input  chipEnableN,
    input  resetOutputEnable,
    input  serial_program_enable_n,
    output dataOut,
    output dataOe,
    output chain_enable_out_n,
    output readyOut,
    output readyOe
  );

  modport loader (
    output configuration_clock_out,
    output chipEnableN,
    output resetOutputEnable,
    output serial_program_enable_n,
    input  dataOut,
    input  dataOe,
    input  chain_enable_out_n,
    input  readyOut,
    input  readyOe
  );
endinterface

// file: shared/serial_config_pkg.sv
/*
  types shared by both ends of the serial configuration link.
  assumes nothing beyond a systemverilog compiler.
*/
package serial_config_pkg;

  typedef enum logic [1:0] {
    MEM_IDLE,
    MEM_STREAM,
    MEM_DONE
  } mem_state_type;

  typedef enum logic [1:0] {
    LOAD_IDLE,
    LOAD_RUN,
    LOAD_FINISH
  } load_state_type;

endpackage

// file: verif/serial_config_memory_readout_tb_top.sv
/*
  self-checking bench: memory and loader joined through the link interface.
  assumes one shared clock; the loader makes the link clock by division.
*/
`timescale 1ns/1ps
module serial_config_memory_readout_tb_top;
  localparam int BITS = 16;
  localparam logic [BITS-1:0] IMAGE = 16'hc5a1;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic start = 1'b0;
  logic holdPosition = 1'b0;
  logic resetPolarityHigh = 1'b0;
  logic bitValid, bitData, busy, done;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  serial_config_if linkBus ();
  serial_config_memory #(.DEPTH(BITS), .CONTENT(IMAGE)) u_serial_config_memory (.clock(clock),
    .reset(reset), .resetPolarityHigh(resetPolarityHigh), .link(linkBus));
  serial_config_loader #(.BITS(BITS)) u_serial_config_loader (.clock(clock), .reset(reset),
    .start(start), .holdPosition(holdPosition), .bitValid(bitValid), .bitData(bitData),
    .busy(busy), .done(done), .link(linkBus));
  serial_config_sva u_serial_config_sva (.clock(clock), .reset(reset),
    .resetPolarityHigh(resetPolarityHigh),
    .configuration_clock_out(linkBus.configuration_clock_out),
    .chipEnableN(linkBus.chipEnableN), .resetOutputEnable(linkBus.resetOutputEnable),
    .serial_program_enable_n(linkBus.serial_program_enable_n), .dataOut(linkBus.dataOut),
    .dataOe(linkBus.dataOe), .chain_enable_out_n(linkBus.chain_enable_out_n),
    .readyOe(linkBus.readyOe));
  always #25 clock = ~clock;
  // bench owns the hang limit; a load takes about 150 cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      num_errors = num_errors + 1;
      $display("unexpected at %0t: timeout", $time);
      close_out();
    end
  end
  function automatic logic expBit(input int i);
    return IMAGE[i];
  endfunction
  task automatic check(input logic got, input logic exp, input string what);
    checks = checks + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask
  task automatic do_reset(input logic pol);
    @(posedge clock);
    reset <= 1'b1;
    resetPolarityHigh <= pol;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    repeat (8) begin
      @(negedge clock);
      check(linkBus.readyOe, 1'b1, "ready released early");
    end
    repeat (4) @(negedge clock);
    check(linkBus.readyOe, 1'b0, "ready still low");
    check(linkBus.readyOut, 1'b0, "ready level not low");
    check(linkBus.dataOe, 1'b0, "data driven while idle");
  endtask
  // expOk low: the memory must never drive, whatever the loader does
  task automatic do_load(input logic hold, input logic expOk);
    int n;
    int waitCount;
    logic sawOe;
    n = 0;
    waitCount = 0;
    sawOe = 1'b0;
    @(posedge clock);
    start <= 1'b1;
    holdPosition <= hold;
    @(posedge clock);
    start <= 1'b0;
    @(negedge clock);
    check(busy, 1'b1, "not busy after start");
    while (done !== 1'b1 && waitCount < 1000) begin
      @(negedge clock);
      waitCount = waitCount + 1;
      if (linkBus.dataOe === 1'b1) sawOe = 1'b1;
      if (bitValid === 1'b1 && expOk && n < BITS) begin
        check(bitData, expBit(n), "wrong bit");
        n = n + 1;
      end
    end
    check(done, 1'b1, "load never finished");
    check(busy, 1'b0, "still busy after done");
    if (expOk) check(32'(n) == BITS, 1'b1, "wrong bit count");
    else check(sawOe, 1'b0, "data driven when disabled");
    repeat (8) @(negedge clock);
    check(linkBus.dataOe, 1'b0, "data driven after last bit");
    check(linkBus.chain_enable_out_n, !(hold && !resetPolarityHigh), "chain level");
  endtask
  initial begin
    logic hold;
    logic term;
    void'($urandom(32'h0000_15c9));
    do_reset(1'b0);
    term = 1'b0;
    // first two fixed: hold then reload into a terminated counter
    for (int i = 0; i < 6; i++) begin
      hold = (i < 2) ? (i == 0) : 1'($urandom_range(1, 0));
      repeat ($urandom_range(7, 0)) @(posedge clock);
      do_load(hold, !term);
      term = hold;
      $display("load test %0d done", i);
    end
    do_reset(1'b1);
    do_load(1'($urandom_range(1, 0)), 1'b0);
    $display("polarity test done");
    close_out();
  end
  task automatic close_out();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
endmodule

// file: verif/serial_config_sva.sv
/*
  checker for the link joining the configuration memory and its loader.
  assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module serial_config_sva (
  // clocking
  input wire logic clock,
  input wire logic reset,
  // setting and link
  input wire logic resetPolarityHigh,
  input wire logic configuration_clock_out,
  input wire logic chipEnableN,
  input wire logic resetOutputEnable,
  input wire logic serial_program_enable_n,
  input wire logic dataOut,
  input wire logic dataOe,
  input wire logic chain_enable_out_n,
  input wire logic readyOe
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic rstLevel;
  assign rstLevel = (resetOutputEnable == resetPolarityHigh);
  ready_hold_a: assert property ($fell(reset) |-> readyOe [*8])
    else $error("ready released early");
  ready_release_a: assert property ($fell(reset) |-> ##[1:12] !readyOe)
    else $error("ready never released");
  standby_float_a: assert property (chipEnableN [*8] |-> !dataOe)
    else $error("data driven in standby");
  reset_float_a: assert property (rstLevel [*8] |-> !dataOe && chain_enable_out_n)
    else $error("data or chain active at reset level");
  chain_data_a: assert property (!chain_enable_out_n |-> !dataOe)
    else $error("data driven after chain enable");
  data_enable_a: assert property ($rose(dataOe) |-> !chipEnableN && !rstLevel)
    else $error("data enabled without enables");
  data_hold_a: assert property ($rose(configuration_clock_out) |=> $stable(dataOut) [*2])
    else $error("data changed too soon");
  link_high_a: assert property ($rose(configuration_clock_out) |-> configuration_clock_out [*3])
    else $error("link clock high too short");
  prog_high_a: assert property (serial_program_enable_n)
    else $error("program enable low");
  cover property ($rose(dataOe));
  cover property ($fell(chain_enable_out_n));
  cover property ($fell(readyOe));
endmodule
